/* File: core/drp_swap_engine.sv */
`default_nettype none
module drp_swap_engine
   import drp_swap_pkg::*;
#(
   parameter int SRC_ACT_CYCLES   = drp_swap_pkg::SRC_ACT_CYC,
   parameter int SWAP_REC_CYCLES  = drp_swap_pkg::SWAP_REC_CYC,
   parameter int PS_SRC_ON_CYCLES = drp_swap_pkg::PS_SRC_ON_CYC,
   parameter int SENDER_CYCLES    = drp_swap_pkg::SENDER_RESP_CYC,
   parameter int OFF_WAIT_CYCLES  = drp_swap_pkg::TURN_OFF_WAIT_CYC,
   parameter int HR_COUNT         = drp_swap_pkg::HARD_RESET_COUNT
)
(
   // clock and reset
   input  wire logic             clock_i,
   input  wire logic             rst_i,
   // port configuration
   input  wire logic             init_source_i,
   input  wire logic             prov_cons_i,
   // protocol layer transmit
   output logic                  tx_req_o,
   output logic [2:0]            tx_kind_o,
   input  wire logic             tx_goodcrc_i,
   input  wire logic [2:0]       tx_ack_kind_i,
   input  wire logic             tx_fail_i,
   // protocol layer receive
   input  wire logic             rx_valid_i,
   input  wire logic [2:0]       rx_kind_i,
   input  wire logic             hard_reset_rx_i,
   input  wire logic             hard_reset_done_i,
   // timers owned elsewhere in the engine
   input  wire logic             sink_wait_cap_exp_i,
   input  wire logic             sink_act_exp_i,
   input  wire logic             ps_trans_exp_i,
   input  wire logic             no_resp_exp_i,
   // device policy manager
   input  wire logic             dpm_hard_reset_req_i,
   input  wire logic             dpm_swap_req_i,
   input  wire logic             dpm_swap_ok_i,
   input  wire logic             dpm_swap_nok_i,
   input  wire logic             dpm_supply_off_i,
   output logic                  dpm_eval_o,
   output logic                  dpm_supply_off_req_o,
   // state report
   output logic                  hard_reset_o,
   output logic                  sink_role_o,
   output drp_swap_pkg::pe_state_t state_o
);
   import drp_swap_pkg::*;

   // every count must fit the one shared down counter
   if (SRC_ACT_CYCLES < 1 || SWAP_REC_CYCLES < 1 || PS_SRC_ON_CYCLES < 1 ||
       SENDER_CYCLES < 1 || OFF_WAIT_CYCLES < 1 || HR_COUNT < 0 || HR_COUNT > 2 ||
       ((SRC_ACT_CYCLES | SWAP_REC_CYCLES | PS_SRC_ON_CYCLES | SENDER_CYCLES |
         OFF_WAIT_CYCLES) >> TMR_W) != 0)
   begin : g_bad_param
      $error("drp_swap_engine: parameter out of range");
   end

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed
   {
      pe_state_t  st;
      logic       sink_role;
      logic       tx_req;
      logic [2:0] tx_kind;
      logic       eval;
      logic       off_req;
      logic       off_asked;
      logic [1:0] hr_cnt;
      logic       hr;
   } eng_t;

   eng_t s_q;
   eng_t s_d;

   // ************************************************************
   // timers
   // ************************************************************
   logic            t_load;
   logic            t_stop;
   logic [TMR_W-1:0] t_cnt;
   logic            t_exp;

   drp_down_timer #(.WIDTH(TMR_W)) u_timer
   (
      .clock_i   (clock_i),
      .rst_i     (rst_i),
      .load_i    (t_load),
      .stop_i    (t_stop),
      .count_i   (t_cnt),
      .expired_o (t_exp)
   );

   // ************************************************************
   // next state
   // ************************************************************
   logic sent_ok;
   logic rx_is;
   logic hr_trig;
   logic hr_allowed;

   always_comb
   begin
      s_d        = s_q;
      t_load     = 1'b0;
      t_stop     = 1'b0;
      t_cnt      = '0;
      // sent only when the ack names the message we asked for
      sent_ok    = s_q.tx_req && tx_goodcrc_i && (tx_ack_kind_i == s_q.tx_kind);
      rx_is      = rx_valid_i;
      hr_allowed = (32'(s_q.hr_cnt) <= HR_COUNT);
      if (sent_ok || tx_fail_i)
         s_d.tx_req = 1'b0;
      s_d.hr = 1'b0;

      // hard reset entry from any state except hard reset itself, by current role
      if (s_q.sink_role)
         hr_trig = ((sink_wait_cap_exp_i || sink_act_exp_i || ps_trans_exp_i ||
                     no_resp_exp_i) && hr_allowed) || dpm_hard_reset_req_i;
      else
         hr_trig = (no_resp_exp_i && hr_allowed) || dpm_hard_reset_req_i;

      if (hard_reset_rx_i && s_q.sink_role && prov_cons_i)
      begin
         s_d.st = ST_SWAP_RECOV;
         t_load = 1'b1;
         t_cnt  = TMR_W'(SWAP_REC_CYCLES);
      end
      else if (hard_reset_rx_i && !s_q.sink_role && !prov_cons_i)
      begin
         s_d.st      = ST_CP_TO_OFF;
         s_d.off_req = 1'b1;
         t_stop      = 1'b1;
      end
      else if (hr_trig && s_q.st != ST_HARD_RESET)
      begin
         s_d.st     = ST_HARD_RESET;
         s_d.hr     = 1'b1;
         s_d.tx_req = 1'b0;
         t_stop     = 1'b1;
         if (s_q.hr_cnt != 2'h3)
            s_d.hr_cnt = s_q.hr_cnt + 2'h1;
      end
      else
      begin
         case (s_q.st)
            ST_READY:
            begin
               s_d.off_asked = 1'b0;
               if (rx_is && rx_kind_i == MSG_SWAP)
               begin
                  s_d.st   = ST_EVAL;
                  s_d.eval = 1'b1;
               end
               else if (dpm_swap_req_i)
               begin
                  s_d.st      = ST_SEND_SWAP;
                  s_d.tx_req  = 1'b1;
                  s_d.tx_kind = MSG_SWAP;
                  t_load      = 1'b1;
                  t_cnt       = TMR_W'(SENDER_CYCLES);
               end
            end
            ST_EVAL:
            begin
               if (dpm_swap_ok_i)
               begin
                  s_d.st      = ST_ACCEPT;
                  s_d.eval    = 1'b0;
                  s_d.tx_req  = 1'b1;
                  s_d.tx_kind = MSG_ACCEPT;
               end
               else if (dpm_swap_nok_i)
               begin
                  s_d.st      = ST_REJECT;
                  s_d.eval    = 1'b0;
                  s_d.tx_req  = 1'b1;
                  s_d.tx_kind = MSG_REJECT;
               end
            end
            ST_ACCEPT:
            begin
               if (sent_ok)
               begin
                  s_d.st = ST_TO_OFF;
                  t_load = 1'b1;
                  t_cnt  = TMR_W'(OFF_WAIT_CYCLES);
               end
            end
            ST_REJECT:
            begin
               if (sent_ok || tx_fail_i)
                  s_d.st = ST_READY;
            end
            ST_SEND_SWAP:
            begin
               if (rx_is && (rx_kind_i == MSG_REJECT || rx_kind_i == MSG_WAIT))
               begin
                  s_d.st = ST_READY;
                  t_stop = 1'b1;
               end
               else if (rx_is && rx_kind_i == MSG_ACCEPT)
               begin
                  s_d.st = ST_TO_OFF;
                  t_load = 1'b1;
                  t_cnt  = TMR_W'(OFF_WAIT_CYCLES);
               end
               else if (t_exp)
               begin
                  s_d.st = ST_READY;
               end
            end
            ST_TO_OFF:
            begin
               // first expiry ends the wait, later ones are source activity
               if (t_exp && !s_q.off_asked)
               begin
                  s_d.off_req   = 1'b1;
                  s_d.off_asked = 1'b1;
                  t_load        = 1'b1;
                  t_cnt         = TMR_W'(SRC_ACT_CYCLES);
               end
               else if (s_q.off_asked && dpm_supply_off_i)
               begin
                  s_d.st      = ST_SRC_OFF;
                  s_d.off_req = 1'b0;
                  s_d.tx_req  = 1'b1;
                  s_d.tx_kind = MSG_PSRDY;
                  t_load      = 1'b1;
                  t_cnt       = TMR_W'(PS_SRC_ON_CYCLES);
               end
               else if (t_exp && s_q.off_asked)
               begin
                  s_d.st      = ST_PING;
                  s_d.tx_req  = 1'b1;
                  s_d.tx_kind = MSG_PING;
               end
            end
            ST_PING:
            begin
               if (sent_ok)
               begin
                  s_d.st = ST_TO_OFF;
                  t_load = 1'b1;
                  t_cnt  = TMR_W'(SRC_ACT_CYCLES);
               end
               else if (tx_fail_i)
               begin
                  s_d.st = ST_HARD_RESET;
                  s_d.hr = 1'b1;
                  s_d.sink_role = !init_source_i;
               end
            end
            ST_SRC_OFF:
            begin
               if (rx_is && rx_kind_i == MSG_PSRDY)
               begin
                  s_d.st        = ST_SNK_STARTUP;
                  s_d.sink_role = 1'b1;
                  t_stop        = 1'b1;
               end
               else if (t_exp || (s_q.tx_req && tx_fail_i))
               begin
                  s_d.st        = ST_HARD_RESET;
                  s_d.hr        = 1'b1;
                  s_d.sink_role = 1'b0;
                  t_stop        = 1'b1;
               end
            end
            ST_HARD_RESET:
            begin
               if (hard_reset_done_i)
               begin
                  if (s_q.sink_role && prov_cons_i)
                  begin
                     s_d.st = ST_SWAP_RECOV;
                     t_load = 1'b1;
                     t_cnt  = TMR_W'(SWAP_REC_CYCLES);
                  end
                  else if (!s_q.sink_role && !prov_cons_i)
                  begin
                     s_d.st      = ST_CP_TO_OFF;
                     s_d.off_req = 1'b1;
                  end
                  else
                  begin
                     s_d.st = ST_READY;
                  end
               end
            end
            ST_SWAP_RECOV:
            begin
               if (t_exp)
               begin
                  s_d.st        = ST_SRC_TO_DEF;
                  s_d.sink_role = 1'b0;
               end
            end
            ST_CP_TO_OFF:
            begin
               if (dpm_supply_off_i)
               begin
                  s_d.st        = ST_SNK_TO_DEF;
                  s_d.off_req   = 1'b0;
                  s_d.sink_role = 1'b1;
               end
            end
            // default operation resumes; outer policy takes over
            ST_SNK_STARTUP, ST_SRC_TO_DEF, ST_SNK_TO_DEF:
            begin
               s_d.st     = ST_READY;
               s_d.hr_cnt = HRCNT_RST;
            end
            default:
            begin
               s_d.st = ST_READY;
            end
         endcase
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         s_q           <= '0;
         s_q.st        <= ST_READY;
         s_q.sink_role <= 1'b0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign tx_req_o             = s_q.tx_req;
   assign tx_kind_o            = s_q.tx_kind;
   assign dpm_eval_o           = s_q.eval;
   assign dpm_supply_off_req_o = s_q.off_req;
   assign hard_reset_o         = s_q.hr;
   assign sink_role_o          = s_q.sink_role;
   assign state_o              = s_q.st;
endmodule : drp_swap_engine
`default_nettype wire

/* File: core/drp_swap_pkg.sv */
`default_nettype none
package drp_swap_pkg;
   // message kinds exchanged with the protocol layer
   localparam logic [2:0] MSG_NONE   = 3'h0;
   localparam logic [2:0] MSG_PING   = 3'h1;
   localparam logic [2:0] MSG_ACCEPT = 3'h2;
   localparam logic [2:0] MSG_REJECT = 3'h3;
   localparam logic [2:0] MSG_WAIT   = 3'h4;
   localparam logic [2:0] MSG_PSRDY  = 3'h5;
   localparam logic [2:0] MSG_SWAP   = 3'h6;
   // timer durations in microseconds, clock 10 MHz
   localparam int CLK_MHZ            = 10;
   localparam int SRC_ACT_US         = 40000;
   localparam int SWAP_REC_US        = 500;
   localparam int PS_SRC_ON_US       = 390000;
   localparam int SENDER_RESP_US     = 24000;
   localparam int TURN_OFF_WAIT_US   = 25;
   localparam int SRC_ACT_CYC        = SRC_ACT_US * CLK_MHZ;
   localparam int SWAP_REC_CYC       = SWAP_REC_US * CLK_MHZ;
   localparam int PS_SRC_ON_CYC      = PS_SRC_ON_US * CLK_MHZ;
   localparam int SENDER_RESP_CYC    = SENDER_RESP_US * CLK_MHZ;
   localparam int TURN_OFF_WAIT_CYC  = TURN_OFF_WAIT_US * CLK_MHZ;
   localparam int HARD_RESET_COUNT   = 2;
   localparam int TMR_W              = 24;
   localparam logic [1:0] HRCNT_RST  = 2'h0;

   typedef enum logic [13:0] {
      ST_READY       = 14'h0001,
      ST_EVAL        = 14'h0002,
      ST_ACCEPT      = 14'h0004,
      ST_REJECT      = 14'h0008,
      ST_SEND_SWAP   = 14'h0010,
      ST_TO_OFF      = 14'h0020,
      ST_PING        = 14'h0040,
      ST_SRC_OFF     = 14'h0080,
      ST_SNK_STARTUP = 14'h0100,
      ST_HARD_RESET  = 14'h0200,
      ST_SWAP_RECOV  = 14'h0400,
      ST_SRC_TO_DEF  = 14'h0800,
      ST_CP_TO_OFF   = 14'h1000,
      ST_SNK_TO_DEF  = 14'h2000
   } pe_state_t;
endpackage : drp_swap_pkg
`default_nettype wire

/* File: core/drp_down_timer.sv */
`default_nettype none
module drp_down_timer
#(
   parameter int WIDTH = 24
)
(
   // clock and reset
   input  wire logic             clock_i,
   input  wire logic             rst_i,
   // control
   input  wire logic             load_i,
   input  wire logic             stop_i,
   input  wire logic [WIDTH-1:0] count_i,
   // status
   output logic                  expired_o
);
   typedef struct packed
   {
      logic [WIDTH-1:0] cnt;
      logic             run;
      logic             exp;
   } tmr_t;

   tmr_t s_q;
   tmr_t s_d;

   if (WIDTH < 2)
   begin : g_bad_width
      $error("timer width too small");
   end

   always_comb
   begin
      s_d     = s_q;
      s_d.exp = 1'b0;
      if (load_i)
      begin
         s_d.cnt = count_i;
         s_d.run = 1'b1;
      end
      else if (stop_i)
      begin
         s_d.run = 1'b0;
      end
      else if (s_q.run)
      begin
         if (s_q.cnt <= WIDTH'(1))
         begin
            s_d.run = 1'b0;
            s_d.exp = 1'b1;
         end
         else
         begin
            s_d.cnt = s_q.cnt - WIDTH'(1);
         end
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign expired_o = s_q.exp;
endmodule : drp_down_timer
`default_nettype wire

/* File: test/drp_partner_model.sv */
`default_nettype none
// ****************************************
// protocol layer and partner acknowledgements
// ****************************************
module drp_partner_model
   import drp_swap_pkg::*;
(
   // clock
   input  wire logic       clock_i,
   // engine transmit side
   input  wire logic       tx_req_i,
   input  wire logic [2:0] tx_kind_i,
   input  wire logic       fail_mode_i,
   output logic            goodcrc_o  = 1'b0,
   output logic [2:0]      ack_kind_o = 3'h0,
   output logic            fail_o     = 1'b0
);
   int         age = 0;
   logic [2:0] kind_q = 3'h0;
   // a new kind restarts the count, so back-to-back requests each get an answer
   always @(negedge clock_i)
   begin
      age = (tx_req_i && tx_kind_i == kind_q) ? age + 1 : 0;
      kind_q = tx_kind_i;
      goodcrc_o <= tx_req_i && age == 2 && !fail_mode_i;
      fail_o <= tx_req_i && age == 2 && fail_mode_i;
      // scrambled kind outside the answer cycle
      ack_kind_o <= (age == 2) ? tx_kind_i : ~tx_kind_i;
   end
endmodule : drp_partner_model
`default_nettype wire

/* File: test/drp_swap_engine_asserts.sv */
`default_nettype none
// ****************************************
// engine port checker
// ****************************************
module drp_swap_engine_asserts
   import drp_swap_pkg::*;
(
   // clock and reset
   input wire logic       clock_i,
   input wire logic       rst_i,
   // stimulus
   input wire logic       prov_cons_i,
   input wire logic       tx_goodcrc_i,
   input wire logic [2:0] tx_ack_kind_i,
   input wire logic       tx_fail_i,
   input wire logic       rx_valid_i,
   input wire logic [2:0] rx_kind_i,
   input wire logic       hard_reset_rx_i,
   input wire logic       dpm_hard_reset_req_i,
   input wire logic       no_resp_exp_i,
   input wire logic       sink_act_exp_i,
   input wire logic       sink_wait_cap_exp_i,
   input wire logic       ps_trans_exp_i,
   input wire logic       dpm_swap_req_i,
   input wire logic       dpm_swap_ok_i,
   input wire logic       dpm_swap_nok_i,
   // engine outputs
   input wire logic       tx_req_o,
   input wire logic [2:0] tx_kind_o,
   input wire logic       dpm_supply_off_req_o,
   input wire logic       sink_role_o,
   input wire pe_state_t  state_o
);
   // hard reset causes take priority, so per-state checks other than AST_PING_FAIL exclude them
   wire logic calm = !hard_reset_rx_i && !dpm_hard_reset_req_i && !no_resp_exp_i
                     && !sink_act_exp_i && !sink_wait_cap_exp_i && !ps_trans_exp_i;
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);

   AST_SWAP_MSG_EVAL: assert property (state_o == ST_READY && rx_valid_i
      && rx_kind_i == MSG_SWAP && !dpm_swap_req_i && calm |=> state_o == ST_EVAL)
      else $error("swap message in ready did not reach evaluate");
   AST_DPM_SEND: assert property (state_o == ST_READY && dpm_swap_req_i && !rx_valid_i
      && calm |=> state_o == ST_SEND_SWAP && tx_req_o && tx_kind_o == MSG_SWAP)
      else $error("manager swap request did not send a swap message");
   AST_EVAL_OK: assert property (state_o == ST_EVAL && dpm_swap_ok_i && !dpm_swap_nok_i
      && calm |=> state_o == ST_ACCEPT) else $error("approved swap not accepted");
   AST_EVAL_NOK: assert property (state_o == ST_EVAL && dpm_swap_nok_i && calm
      |=> state_o == ST_REJECT) else $error("refused swap not rejected");
   AST_ACCEPT_SENT: assert property (state_o == ST_ACCEPT && tx_goodcrc_i
      && tx_ack_kind_i == MSG_ACCEPT && calm |=> state_o == ST_TO_OFF)
      else $error("sent accept did not lead to transition to off");
   AST_RX_ACCEPT: assert property (state_o == ST_SEND_SWAP && rx_valid_i
      && rx_kind_i == MSG_ACCEPT && calm |=> state_o == ST_TO_OFF)
      else $error("accept answer did not lead to transition to off");
   AST_RX_REFUSE: assert property (state_o == ST_SEND_SWAP && rx_valid_i && calm
      && (rx_kind_i == MSG_REJECT || rx_kind_i == MSG_WAIT) |=> state_o == ST_READY)
      else $error("reject or wait did not return to ready");
   AST_PSRDY_RX: assert property (state_o == ST_SRC_OFF && rx_valid_i && !tx_req_o
      && rx_kind_i == MSG_PSRDY && calm |=> state_o == ST_SNK_STARTUP && sink_role_o)
      else $error("partner ready did not start sink role");
   AST_PING_FAIL: assert property (state_o == ST_PING && tx_fail_i && !hard_reset_rx_i
      |=> state_o == ST_HARD_RESET) else $error("failed ping did not hard reset");
   AST_PC_RECOVER: assert property (hard_reset_rx_i && prov_cons_i && sink_role_o
      |=> state_o == ST_SWAP_RECOV) else $error("hard reset signaling missed recovery");
   AST_CP_OFF: assert property (hard_reset_rx_i && !prov_cons_i && !sink_role_o
      |=> state_o == ST_CP_TO_OFF ##[0:1] dpm_supply_off_req_o)
      else $error("hard reset signaling did not turn supply off");
   AST_SWAP_FROM_READY: assert property ((state_o == ST_EVAL || state_o == ST_SEND_SWAP)
      && state_o != $past(state_o) |-> $past(state_o) == ST_READY)
      else $error("swap started outside ready");

   cover property (state_o == ST_SNK_STARTUP);
   cover property (state_o == ST_SWAP_RECOV);
   cover property (state_o == ST_PING && tx_goodcrc_i);
endmodule : drp_swap_engine_asserts

bind drp_swap_engine drp_swap_engine_asserts drp_swap_engine_asserts_i (.clock_i, .rst_i,
   .prov_cons_i, .tx_goodcrc_i, .tx_ack_kind_i, .tx_fail_i, .rx_valid_i, .rx_kind_i,
   .hard_reset_rx_i, .dpm_hard_reset_req_i, .no_resp_exp_i, .sink_act_exp_i,
   .sink_wait_cap_exp_i, .ps_trans_exp_i, .dpm_swap_req_i, .dpm_swap_ok_i, .dpm_swap_nok_i,
   .tx_req_o, .tx_kind_o, .dpm_supply_off_req_o, .sink_role_o, .state_o);
`default_nettype wire

/* File: test/drp_swap_engine_tb.sv */
`default_nettype none
module drp_swap_engine_tb
   import drp_swap_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // shortened timers keep the run brief
   // ****************************************
   localparam int OFF_W = 20;
   localparam int ACT   = 40;
   localparam int REC   = 30;
   localparam int ON    = 50;
   localparam int SND   = 30;
   logic clock_i = 1'b0, rst_i = 1'b1, init_source_i = 1'b1, prov_cons_i = 1'b1;
   logic rx_valid_i = 1'b0, hard_reset_rx_i = 1'b0, hard_reset_done_i = 1'b0;
   logic sink_wait_cap_exp_i = 1'b0, sink_act_exp_i = 1'b0, ps_trans_exp_i = 1'b0;
   logic no_resp_exp_i = 1'b0, dpm_hard_reset_req_i = 1'b0, dpm_swap_req_i = 1'b0;
   logic dpm_swap_ok_i = 1'b0, dpm_swap_nok_i = 1'b0, dpm_supply_off_i = 1'b0;
   logic fail_mode = 1'b0;
   logic [2:0] rx_kind_i = 3'h0;
   logic tx_goodcrc_i, tx_fail_i, tx_req_o, dpm_eval_o, dpm_supply_off_req_o;
   logic hard_reset_o, sink_role_o;
   logic [2:0] tx_ack_kind_i, tx_kind_o;
   pe_state_t state_o;
   int failures = 0;
   int comparisons = 0;
   int waited = 0;

   drp_swap_engine #(.SRC_ACT_CYCLES(ACT), .SWAP_REC_CYCLES(REC), .PS_SRC_ON_CYCLES(ON),
      .SENDER_CYCLES(SND), .OFF_WAIT_CYCLES(OFF_W)) drp_swap_engine_i (.clock_i, .rst_i,
      .init_source_i, .prov_cons_i, .tx_req_o, .tx_kind_o, .tx_goodcrc_i, .tx_ack_kind_i,
      .tx_fail_i, .rx_valid_i, .rx_kind_i, .hard_reset_rx_i, .hard_reset_done_i,
      .sink_wait_cap_exp_i, .sink_act_exp_i, .ps_trans_exp_i, .no_resp_exp_i,
      .dpm_hard_reset_req_i, .dpm_swap_req_i, .dpm_swap_ok_i, .dpm_swap_nok_i,
      .dpm_supply_off_i, .dpm_eval_o, .dpm_supply_off_req_o, .hard_reset_o, .sink_role_o,
      .state_o);
   drp_partner_model drp_partner_model_i (.clock_i, .tx_req_i(tx_req_o), .tx_kind_i(tx_kind_o),
      .fail_mode_i(fail_mode), .goodcrc_o(tx_goodcrc_i), .ack_kind_o(tx_ack_kind_i),
      .fail_o(tx_fail_i));

   initial
   begin
      forever #50 clock_i = ~clock_i;
   end

   // ****************************************
   // shared helpers
   // ****************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic pulse(ref logic s);
      @(negedge clock_i);
      s = 1'b1;
      @(negedge clock_i);
      s = 1'b0;
   endtask : pulse

   task automatic rx(input logic [2:0] k);
      rx_kind_i = k;
      pulse(rx_valid_i);
   endtask : rx

   task automatic wait_state(input pe_state_t st, input int lim);
      waited = 0;
      while (state_o !== st && waited < lim)
      begin
         @(negedge clock_i);
         waited++;
      end
      check(state_o, st);
   endtask : wait_state

   task automatic wait_tx_idle();
      int n = 0;
      while (tx_req_o !== 1'b0 && n < 10)
      begin
         @(negedge clock_i);
         n++;
      end
      check(tx_req_o, 1'b0);
   endtask : wait_tx_idle

   task automatic restart(input logic pc);
      @(negedge clock_i);
      rst_i = 1'b1;
      prov_cons_i = pc;
      init_source_i = 1'b1;
      {dpm_supply_off_i, dpm_swap_ok_i, dpm_swap_nok_i, fail_mode} = 4'h0;
      repeat (3) @(negedge clock_i);
      rst_i = 1'b0;
      check(state_o, ST_READY);
   endtask : restart

   task automatic to_src_off();
      int n = 0;
      pulse(dpm_swap_req_i);
      wait_state(ST_SEND_SWAP, 3);
      check(tx_kind_o, MSG_SWAP);
      wait_tx_idle();
      rx(MSG_ACCEPT);
      wait_state(ST_TO_OFF, 3);
      while (dpm_supply_off_req_o !== 1'b1 && n < 100)
      begin
         @(negedge clock_i);
         n++;
      end
      check(n > OFF_W - 4 && n < OFF_W + 4, 1'b1);
      dpm_supply_off_i = 1'b1;
      wait_state(ST_SRC_OFF, 3);
      check(tx_kind_o, MSG_PSRDY);
      wait_tx_idle();
   endtask : to_src_off

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_swap_out();
      restart(1'b1);
      to_src_off();
      rx(MSG_PSRDY);
      wait_state(ST_READY, 3);
      check(sink_role_o, 1'b1);
      pulse(hard_reset_rx_i);
      wait_state(ST_SWAP_RECOV, 3);
      wait_state(ST_SRC_TO_DEF, REC + 5);
      check(waited > REC - 4, 1'b1);
   endtask : t_swap_out

   task automatic t_pc_hard();
      restart(1'b1);
      to_src_off();
      rx(MSG_PSRDY);
      wait_state(ST_READY, 3);
      pulse(sink_act_exp_i);
      wait_state(ST_HARD_RESET, 3);
      pulse(hard_reset_done_i);
      wait_state(ST_SWAP_RECOV, 3);
      pulse(ps_trans_exp_i);
      wait_state(ST_HARD_RESET, 3);
      pulse(hard_reset_done_i);
      wait_state(ST_SWAP_RECOV, 3);
      pulse(sink_wait_cap_exp_i);
      wait_state(ST_HARD_RESET, 3);
      pulse(hard_reset_done_i);
      wait_state(ST_SWAP_RECOV, 3);
      // third hard reset used the last allowed count
      pulse(no_resp_exp_i);
      @(negedge clock_i);
      check(state_o, ST_SWAP_RECOV);
   endtask : t_pc_hard

   task automatic t_src_off_timeout();
      restart(1'b1);
      to_src_off();
      wait_state(ST_HARD_RESET, ON + 10);
      check(hard_reset_o, 1'b1);
      check(sink_role_o, 1'b0);
   endtask : t_src_off_timeout

   task automatic t_eval();
      restart(1'b1);
      dpm_swap_nok_i = 1'b1;
      rx(MSG_SWAP);
      check(dpm_eval_o, 1'b1);
      wait_state(ST_REJECT, 3);
      wait_state(ST_READY, 10);
      dpm_swap_nok_i = 1'b0;
      dpm_swap_ok_i = 1'b1;
      rx(MSG_SWAP);
      wait_state(ST_ACCEPT, 3);
      check(tx_kind_o, MSG_ACCEPT);
      wait_state(ST_TO_OFF, 10);
      wait_state(ST_PING, OFF_W + ACT + 10);
      check(tx_kind_o, MSG_PING);
      wait_state(ST_TO_OFF, 10);
      fail_mode = 1'b1;
      init_source_i = 1'b0;
      wait_state(ST_PING, ACT + 10);
      wait_state(ST_HARD_RESET, 10);
      check(sink_role_o, 1'b1);
   endtask : t_eval

   task automatic t_send_refuse();
      restart(1'b1);
      for (int i = 0; i < 2; i++)
      begin
         pulse(dpm_swap_req_i);
         wait_state(ST_SEND_SWAP, 3);
         wait_tx_idle();
         rx(i == 0 ? MSG_REJECT : MSG_WAIT);
         wait_state(ST_READY, 3);
      end
      pulse(dpm_swap_req_i);
      wait_state(ST_SEND_SWAP, 3);
      wait_state(ST_READY, SND + 10);
      check(waited > SND - 6, 1'b1);
   endtask : t_send_refuse

   task automatic t_cp();
      restart(1'b0);
      pulse(no_resp_exp_i);
      wait_state(ST_HARD_RESET, 3);
      pulse(hard_reset_done_i);
      wait_state(ST_CP_TO_OFF, 3);
      @(negedge clock_i);
      check(dpm_supply_off_req_o, 1'b1);
      dpm_supply_off_i = 1'b1;
      wait_state(ST_SNK_TO_DEF, 3);
      restart(1'b0);
      pulse(hard_reset_rx_i);
      wait_state(ST_CP_TO_OFF, 3);
      pulse(dpm_hard_reset_req_i);
      wait_state(ST_HARD_RESET, 3);
   endtask : t_cp

   task automatic test_done();
      $display("failures=%0d comparisons=%0d", failures, comparisons);
      if (failures == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : test_done

   initial
   begin
      repeat (10) @(negedge clock_i);
      rst_i = 1'b0;
      t_swap_out();
      t_pc_hard();
      t_src_off_timeout();
      t_eval();
      t_send_refuse();
      t_cp();
      test_done();
   end

   // the scenarios need well under 2000 cycles
   initial
   begin
      repeat (5000) @(posedge clock_i);
      failures++;
      test_done();
   end
endmodule : drp_swap_engine_tb
`default_nettype wire
